//--- logic/aumdf_pkg.sv
package aumdf_pkg;

  // operation codes seen on the sequencer command
  localparam logic [7:0] OP_MUL  = 8'h0D;
  localparam logic [7:0] OP_MULH = 8'h0C;
  localparam logic [7:0] OP_DIV  = 8'h0A;
  localparam logic [7:0] OP_MODX = 8'h08;
  localparam logic [7:0] OP_FADD = 8'h4C;

  // selector codes for floating add
  localparam logic [1:0] SEL_A = 2'h1;
  localparam logic [1:0] SEL_D = 2'h3;

  // condition indicator values
  localparam logic [1:0] CC_NONE = 2'h0;
  localparam logic [1:0] CC_NEG  = 2'h1;
  localparam logic [1:0] CC_ZERO = 2'h2;
  localparam logic [1:0] CC_POS  = 2'h3;

  // exponent limits, excess-64 stored form
  localparam logic [7:0] EXP_BIAS = 8'h40;
  localparam logic [7:0] EXP_MAX  = 8'h7F;
  localparam logic [7:0] EXP_MIN  = 8'h00;

  // working fraction: bit 60 carry, 59:4 fraction, 3:0 spare digit
  localparam logic [60:0] SGL_MASK = 61'h1FFF_FFFF_0000_0000;
  localparam logic [60:0] DBL_MASK = 61'h1FFF_FFFF_FFFF_FFF0;

  // apb register byte offsets
  localparam logic [11:0] OFF_ACC_A  = 12'h000;
  localparam logic [11:0] OFF_ACC_B  = 12'h004;
  localparam logic [11:0] OFF_IDX1   = 12'h008;
  localparam logic [11:0] OFF_IDX2   = 12'h00C;
  localparam logic [11:0] OFF_IDX3   = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h014;

  // status field positions
  localparam int unsigned ST_OV_BIT   = 0;
  localparam int unsigned ST_CC_LSB   = 2;
  localparam int unsigned ST_BUSY_BIT = 8;

  // reset values
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam logic [31:0] IDX_RST = 32'h0000_0000;

  // command from the instruction sequencer
  typedef struct packed {
    logic        start;
    logic [7:0]  opcode;
    logic [1:0]  m_sel;
    logic        cond_en;
    logic        literal;
    logic [17:0] addr;
    logic [63:0] operand;
  } aumdf_cmd_type;

  // sequencing states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_EXEC  = 6'h02,
    ST_ALIGN = 6'h04,
    ST_ADD   = 6'h08,
    ST_NORM  = 6'h10,
    ST_DONE  = 6'h20
  } aumdf_state_type;

endpackage

//--- logic/aumdf_unit.sv
`timescale 1ns/10ps
// Functional notes
// - full multiply A times operand into D, no overflow
// - literal multiply uses sign-extended 18-bit address
// - zero products always carry positive sign
// - half-word multiply A by 16-bit into A
// - half-word product overflow when sign carries differ
// - literal half-word multiply uses low 16 address bits
// - divide D by word, quotient B, remainder A
// - remainder dividend sign, zero results positive
// - zero divisor sets overflow, no division
// - quotient wider than 32 bits sets overflow
// - literal divide uses sign-extended 18-bit address
// - modify index adds operand to selected register
// - index condition from leftmost bit and zero
// - index sum beyond 32 bits sets overflow
// - condition reflects result when flag set
// - floating add into A single or D double
// - align smaller exponent one digit per step
// - single precision keeps last shifted-out digit
// - fraction carry shifts right, exponent overflow ends
// - normalize left, exponent underflow ends operation
// - exponent overflow or underflow sets overflow
// - zero fraction sum gives all-zero result
// - exponents are excess-64 stored values
module aumdf_unit
  import aumdf_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [11:0]             paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire aumdf_pkg::aumdf_cmd_type cmd,
  output logic                         done,
  output logic                         busy,
  output logic                         ov_flag,
  output logic [1:0]                   cond_code
);
  import aumdf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // storage
  aumdf_state_type state_q;              // sequencer state
  logic [31:0]     a_q, b_q;             // primary and memory accumulators
  logic [31:0]     x_q [1:3];            // index registers
  logic            ov_q;                 // overflow indicator
  logic [1:0]      cc_q;                 // condition indicator
  logic [31:0]     prdata_q;             // registered read data
  logic [60:0]     fa_q, fb_q;           // working fractions
  logic [7:0]      ea_q, eb_q;           // working exponents
  logic            sa_q, sb_q;           // working signs
  logic            dbl_q;                // double precision in flight

  // unit write strobes and values
  logic            a_we, b_we, ov_set, cc_we;
  logic [3:1]      x_we;
  logic [31:0]     a_d, b_d, x_d;
  logic [1:0]      cc_d;
  logic            norm_end;             // normalization finished this cycle

  ////////////////////////////////////////////////////////////////////////////
  // fixed-point arithmetic
  logic [31:0]        lit32;             // address field sign-extended
  logic [31:0]        mul_src;           // full multiplier
  logic [15:0]        half_src;          // half-word multiplier
  logic signed [63:0] mul_p;             // full product
  logic signed [47:0] mulh_p;            // half-word product
  logic signed [64:0] dvd, dvs, dvs_nz;  // dividend, divisor
  logic signed [64:0] quo, rem;          // quotient, remainder
  logic               div_zero, div_ov;  // divide exceptions
  logic               mulh_ov;           // half-word product too wide
  logic [1:0]         x_idx;             // index register select
  logic [31:0]        x_cur;             // selected index content
  logic [33:0]        x_sum;             // widened index sum

  assign lit32    = {{14{cmd.addr[17]}}, cmd.addr};
  assign mul_src  = cmd.literal ? lit32 : cmd.operand[31:0];
  assign half_src = cmd.literal ? cmd.addr[15:0] : cmd.operand[15:0];
  // two's complement zero is positive by construction
  assign mul_p    = $signed(a_q) * $signed(mul_src);
  assign mulh_p   = $signed(a_q) * $signed(half_src);
  // product must fit sign plus 31 magnitude bits
  assign mulh_ov  = (mulh_p[47:31] != {17{mulh_p[31]}});

  // 65-bit division keeps the most negative dividend legal
  assign dvd      = {a_q[31], a_q, b_q};
  assign dvs      = cmd.literal ? {{33{lit32[31]}}, lit32}
                                : {{33{cmd.operand[31]}}, cmd.operand[31:0]};
  assign div_zero = (dvs == 65'sh0_0000_0000_0000_0000);
  assign dvs_nz   = div_zero ? 65'sh0_0000_0000_0000_0001 : dvs;
  assign quo      = dvd / dvs_nz;        // truncates toward zero
  assign rem      = dvd % dvs_nz;        // remainder follows dividend sign
  assign div_ov   = (quo[64:31] != {34{quo[31]}});

  assign x_idx    = cmd.m_sel;
  assign x_cur    = (x_idx == 2'h0) ? 32'h0000_0000 : x_q[x_idx];
  // index content unsigned, operand signed
  assign x_sum    = {2'h0, x_cur} + {{2{mul_src[31]}}, mul_src};

  // condition code of a signed result
  function automatic logic [1:0] cc_of(input logic neg, input logic zero);
    if (zero) begin
      return CC_ZERO;
    end
    return neg ? CC_NEG : CC_POS;
  endfunction

  // apply precision mask: single keeps one extra digit
  function automatic logic [60:0] keep(input logic [60:0] f, input logic dbl);
    return f & (dbl ? DBL_MASK : SGL_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state; command held stable until done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cmd.start) begin
            if (cmd.opcode == OP_FADD && (cmd.m_sel == SEL_A || cmd.m_sel == SEL_D)) begin
              state_q <= ST_ALIGN;
            end else begin
              state_q <= ST_EXEC;
            end
          end
        end
        ST_EXEC:  state_q <= ST_DONE;
        ST_ALIGN: begin
          if (ea_q == eb_q) begin
            state_q <= ST_ADD;
          end
        end
        ST_ADD:   state_q <= ST_NORM;
        ST_NORM: begin
          if (norm_end) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE:  state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  assign done = (state_q == ST_DONE);    // one-cycle pulse
  assign busy = (state_q != ST_IDLE);

  // normalization ends on zero, exponent limit, or a leading digit
  assign norm_end = (fa_q == 61'h0) || fa_q[60] ? (fa_q == 61'h0 || ea_q == EXP_MAX)
                                                : (fa_q[59:56] != 4'h0 || ea_q == EXP_MIN);

  ////////////////////////////////////////////////////////////////////////////
  // floating working registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fa_q  <= '0;
      fb_q  <= '0;
      ea_q  <= 8'h00;
      eb_q  <= 8'h00;
      sa_q  <= 1'b0;
      sb_q  <= 1'b0;
      dbl_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // unpack accumulator and memory operand
          dbl_q <= (cmd.m_sel == SEL_D);
          sa_q  <= a_q[31];
          ea_q  <= {1'b0, a_q[30:24]};
          sb_q  <= cmd.operand[63];
          if (cmd.m_sel == SEL_D) begin
            fa_q <= {1'b0, a_q[23:0], b_q, 4'h0};
            fb_q <= {1'b0, cmd.operand[55:0], 4'h0};
            eb_q <= {1'b0, cmd.operand[62:56]};
          end else begin
            fa_q <= {1'b0, a_q[23:0], 36'h0_0000_0000};
            fb_q <= {1'b0, cmd.operand[23:0], 36'h0_0000_0000};
            eb_q <= {1'b0, cmd.operand[30:24]};
            sb_q <= cmd.operand[31];
          end
        end
        ST_ALIGN: begin
          // biased exponents compare as true ones
          if (ea_q < eb_q) begin
            fa_q <= keep(fa_q >> 4, dbl_q);
            ea_q <= ea_q + 8'h01;
          end else if (eb_q < ea_q) begin
            fb_q <= keep(fb_q >> 4, dbl_q);
            eb_q <= eb_q + 8'h01;
          end
        end
        ST_ADD: begin
          // signed-magnitude addition
          if (sa_q == sb_q) begin
            fa_q <= fa_q + fb_q;
          end else if (fa_q >= fb_q) begin
            fa_q <= fa_q - fb_q;
          end else begin
            fa_q <= fb_q - fa_q;
            sa_q <= sb_q;
          end
        end
        ST_NORM: begin
          if (!norm_end) begin
            if (fa_q[60]) begin
              fa_q <= fa_q >> 4;         // carry enters top digit
              ea_q <= ea_q + 8'h01;
            end else begin
              fa_q <= fa_q << 4;
              ea_q <= ea_q - 8'h01;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // results of each operation
  always_comb begin
    a_we   = 1'b0;
    b_we   = 1'b0;
    x_we   = 3'h0;
    a_d    = a_q;
    b_d    = b_q;
    x_d    = x_sum[31:0];
    ov_set = 1'b0;
    cc_we  = 1'b0;
    cc_d   = cc_q;
    if (state_q == ST_EXEC) begin
      unique case (cmd.opcode)
        OP_MUL: begin
          a_we  = 1'b1;
          b_we  = 1'b1;
          a_d   = mul_p[63:32];
          b_d   = mul_p[31:0];
          cc_we = cmd.cond_en;
          cc_d  = cc_of(mul_p[63], mul_p == 64'sh0);
        end
        OP_MULH: begin
          a_we   = 1'b1;
          a_d    = mulh_p[31:0];
          ov_set = mulh_ov;
          cc_we  = cmd.cond_en;
          cc_d   = cc_of(mulh_p[31], mulh_p[31:0] == 32'h0000_0000);
        end
        OP_DIV: begin
          ov_set = div_zero || div_ov;
          if (!div_zero && !div_ov) begin
            b_we  = 1'b1;
            a_we  = 1'b1;
            b_d   = quo[31:0];
            a_d   = rem[31:0];
            cc_we = cmd.cond_en;
            cc_d  = cc_of(quo[31], quo[31:0] == 32'h0000_0000);
          end
        end
        OP_MODX: begin
          if (x_idx != 2'h0) begin
            x_we[x_idx] = 1'b1;
            ov_set      = (x_sum[33:32] != 2'h0);
            cc_we       = cmd.cond_en;
            cc_d        = cc_of(x_sum[31], x_sum[31:0] == 32'h0000_0000);
          end
        end
        default: begin
        end
      endcase
    end else if (state_q == ST_NORM && norm_end) begin
      cc_we = cmd.cond_en;
      if (fa_q == 61'h0 || (!fa_q[60] && ea_q == EXP_MIN && fa_q[59:56] == 4'h0)) begin
        // zero sum or underflow: all-zero result
        ov_set = (fa_q != 61'h0);
        a_we   = 1'b1;
        b_we   = dbl_q;
        a_d    = 32'h0000_0000;
        b_d    = 32'h0000_0000;
        cc_d   = CC_ZERO;
      end else if (fa_q[60]) begin
        ov_set = 1'b1;                   // exponent overflow ends
        cc_we  = 1'b0;
      end else begin
        a_we = 1'b1;
        b_we = dbl_q;
        a_d  = {sa_q, ea_q[6:0], fa_q[59:36]};
        b_d  = fa_q[35:4];
        cc_d = cc_of(sa_q, 1'b0);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic apb_acc, apb_wr, mapped, data_reg;
  assign apb_acc  = psel && penable;
  assign mapped   = (paddr <= OFF_STATUS) && (paddr[1:0] == 2'h0);
  assign data_reg = (paddr != OFF_STATUS);
  assign apb_wr   = apb_acc && pwrite && mapped && !(busy && data_reg);
  assign pready   = 1'b1;
  // unmapped or writes to operands while busy are errors
  assign pslverr  = apb_acc && (!mapped || (pwrite && busy && data_reg));
  assign prdata   = prdata_q;

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (paddr)
        OFF_ACC_A:  prdata_q <= a_q;
        OFF_ACC_B:  prdata_q <= b_q;
        OFF_IDX1:   prdata_q <= x_q[1];
        OFF_IDX2:   prdata_q <= x_q[2];
        OFF_IDX3:   prdata_q <= x_q[3];
        OFF_STATUS: prdata_q <= {23'h00_0000, busy, 4'h0, cc_q, 1'b0, ov_q};
        default:    prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulators and index registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= ACC_RST;
      b_q <= ACC_RST;
      for (int i = 1; i <= 3; i++) begin
        x_q[i] <= IDX_RST;
      end
    end else begin
      if (a_we) begin
        a_q <= a_d;
      end else if (apb_wr && paddr == OFF_ACC_A) begin
        a_q <= pwdata;
      end
      if (b_we) begin
        b_q <= b_d;
      end else if (apb_wr && paddr == OFF_ACC_B) begin
        b_q <= pwdata;
      end
      for (int i = 1; i <= 3; i++) begin
        if (x_we[i]) begin
          x_q[i] <= x_d;
        end else if (apb_wr && paddr == OFF_ACC_B + 12'(4 * i)) begin
          x_q[i] <= pwdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow and condition indicators; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_q <= 1'b0;
    end else if (ov_set) begin
      ov_q <= 1'b1;
    end else if (apb_wr && paddr == OFF_STATUS && pwdata[ST_OV_BIT]) begin
      ov_q <= 1'b0;                      // otherwise unchanged
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_q <= CC_NONE;
    end else if (cc_we) begin
      cc_q <= cc_d;
    end
  end

  assign ov_flag   = ov_q;
  assign cond_code = cc_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic sw_clr;
  assign sw_clr = apb_wr && paddr == OFF_STATUS && pwdata[ST_OV_BIT];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_done_once;
    done |=> !done && !busy;
  endproperty
  a_done_once: assert property (p_done_once) else $error("done longer than one cycle");

  property p_mul_d;
    state_q == ST_EXEC && cmd.opcode == OP_MUL |=> {a_q, b_q} == $past(mul_p) && done;
  endproperty
  a_mul_d: assert property (p_mul_d) else $error("multiply result wrong");

  property p_mul_lit;
    state_q == ST_EXEC && cmd.opcode == OP_MUL && cmd.literal
      |=> {a_q, b_q} == 64'($past($signed(a_q)) * $signed($past(lit32)));
  endproperty
  a_mul_lit: assert property (p_mul_lit) else $error("literal multiply wrong");

  property p_mulh_ov;
    state_q == ST_EXEC && cmd.opcode == OP_MULH && mulh_ov
      |=> ov_q ##1 (ov_q || $past(sw_clr));
  endproperty
  a_mulh_ov: assert property (p_mulh_ov) else $error("half multiply overflow missed");

  property p_div_zero;
    state_q == ST_EXEC && cmd.opcode == OP_DIV && div_zero
      |=> ov_q && $stable(a_q) && $stable(b_q);
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("zero divisor not trapped");

  property p_rem_sign;
    state_q == ST_EXEC && cmd.opcode == OP_DIV && !div_zero && !div_ov && rem != 65'sh0
      |=> a_q[31] == $past(a_q[31]);
  endproperty
  a_rem_sign: assert property (p_rem_sign) else $error("remainder sign wrong");

  property p_ov_hold;
    !ov_set && !sw_clr |=> $stable(ov_q);
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("overflow changed");

  property p_modx_cc;
    state_q == ST_EXEC && cmd.opcode == OP_MODX && cmd.cond_en && x_idx != 2'h0 && x_sum[31]
      |=> cond_code == CC_NEG;
  endproperty
  a_modx_cc: assert property (p_modx_cc) else $error("index condition wrong");

  property p_fadd_end;
    state_q == ST_IDLE && cmd.start && cmd.opcode == OP_FADD && cmd.m_sel == SEL_A
      |-> ##[3:160] done;
  endproperty
  a_fadd_end: assert property (p_fadd_end) else $error("floating add hung");

  property p_fzero;
    state_q == ST_NORM && fa_q == 61'h0 |=> a_q == 32'h0000_0000 && done;
  endproperty
  a_fzero: assert property (p_fzero) else $error("zero sum not cleared");

  c_mul:   cover property (state_q == ST_EXEC && cmd.opcode == OP_MUL);
  c_div0:  cover property (state_q == ST_EXEC && cmd.opcode == OP_DIV && div_zero);
  c_fcarr: cover property (state_q == ST_NORM && fa_q[60]);
  c_fdone: cover property (state_q == ST_NORM && norm_end && !ov_set);

endmodule // aumdf_unit

//--- test/aumdf_seq_model.sv
`timescale 1ns/10ps
// stand-in for the instruction sequencer on the command side
module aumdf_seq_model
  import aumdf_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     done,
  output aumdf_pkg::aumdf_cmd_type      cmd
);
  ////////////////////////////////////////////////////////////////
  // idle command at time zero
  initial cmd = '0;

  ////////////////////////////////////////////////////////////////
  // one command: start for one cycle, fields held until done
  task automatic issue(input logic [7:0] oc, input logic [1:0] ms, input logic ce,
                       input logic li, input logic [17:0] ad, input logic [63:0] od);
    int n;
    @(posedge pclk);
    cmd <= '{1'b1, oc, ms, ce, li, ad, od};
    @(posedge pclk);
    cmd.start <= 1'b0;
    for (n = 0; n < 300 && done !== 1'b1; n++) @(negedge pclk);
    @(posedge pclk);
    // released fields no longer carry the old command
    cmd <= '{1'b0, ~oc, ~ms, ~ce, ~li, ~ad, ~od};
  endtask
endmodule // aumdf_seq_model

//--- test/tb.sv
`timescale 1ns/10ps
module tb;
  import aumdf_pkg::*;
  logic            pclk = 0;
  logic            presetn = 0;
  logic            psel = 0;
  logic            penable = 0;
  logic            pwrite = 0;
  logic [11:0]     paddr = '0;
  logic [31:0]     pwdata = '0;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  aumdf_cmd_type   cmd;
  logic            done;
  logic            busy;
  logic            ov_flag;
  logic [1:0]      cond_code;
  int              n_fail = 0;
  int              checked = 0;
  int              cyc = 0;
  logic [31:0]     rv;
  logic            re;

  ////////////////////////////////////////////////////////////////
  // 100 MHz clock
  always #5 pclk = ~pclk;

  aumdf_unit dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd(cmd), .done(done), .busy(busy),
    .ov_flag(ov_flag), .cond_code(cond_code));
  aumdf_seq_model seq_u (.pclk(pclk), .done(done), .cmd(cmd));

  ////////////////////////////////////////////////////////////////
  // verdict and end of run
  task test_done;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end

  // value compare
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // apb transfer: setup, access until pready, then release
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, 64'(e), 64'(rv));
  endtask

  // overflow and condition indicators
  task fl(input logic o, input logic [1:0] c);
    chk("ov", 64'(o), 64'(ov_flag));
    chk("cc", 64'(c), 64'(cond_code));
  endtask

  task op(input logic [7:0] oc, input logic [1:0] ms, input logic ce, input logic li,
          input logic [17:0] ad, input logic [63:0] od);
    seq_u.issue(oc, ms, ce, li, ad, od);
    // pulse over and unit idle again once the command is released
    @(negedge pclk);
    chk("busy", 64'h0, 64'(busy));
    chk("done", 64'h0, 64'(done));
  endtask

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rc("status", OFF_STATUS, 32'h0000_0000);
    wr(OFF_ACC_A, 32'hFFFF_FFFD);
    op(OP_MUL, 2'h0, 1'b1, 1'b0, 18'h0_0000, 64'h5);
    rc("a", OFF_ACC_A, 32'hFFFF_FFFF);
    rc("b", OFF_ACC_B, 32'hFFFF_FFF1);
    fl(1'b0, CC_NEG);
    wr(OFF_ACC_A, 32'h0000_0000);
    op(OP_MUL, 2'h0, 1'b1, 1'b0, 18'h0_0000, 64'hFFFF_FFF9);
    rc("a", OFF_ACC_A, 32'h0000_0000);
    fl(1'b0, CC_ZERO);
    wr(OFF_ACC_A, 32'hFFFF_FFFD);
    op(OP_MUL, 2'h0, 1'b1, 1'b1, 18'h3_FFFE, 64'h0);
    rc("b", OFF_ACC_B, 32'h0000_0006);
    wr(OFF_ACC_A, 32'h4000_0000);
    op(OP_MULH, 2'h0, 1'b0, 1'b0, 18'h0_0000, 64'h2);
    rc("a", OFF_ACC_A, 32'h8000_0000);
    fl(1'b1, CC_POS);
    wr(OFF_STATUS, 32'h0000_0001);
    wr(OFF_ACC_A, 32'h0000_0005);
    op(OP_MULH, 2'h0, 1'b1, 1'b1, 18'h0_FFFF, 64'h0);
    rc("a", OFF_ACC_A, 32'hFFFF_FFFB);
    fl(1'b0, CC_NEG);
    wr(OFF_ACC_A, 32'hFFFF_FFFF);
    wr(OFF_ACC_B, 32'hFFFF_FFF9);
    op(OP_DIV, 2'h0, 1'b1, 1'b0, 18'h0_0000, 64'h2);
    rc("q", OFF_ACC_B, 32'hFFFF_FFFD);
    rc("r", OFF_ACC_A, 32'hFFFF_FFFF);
    op(OP_DIV, 2'h0, 1'b1, 1'b0, 18'h0_0000, 64'h0);
    rc("q", OFF_ACC_B, 32'hFFFF_FFFD);
    rc("status", OFF_STATUS, 32'h0000_0005);
    fl(1'b1, CC_NEG);
    wr(OFF_STATUS, 32'h0000_0001);
    wr(OFF_ACC_A, 32'h0000_0000);
    wr(OFF_ACC_B, 32'h0000_0006);
    op(OP_DIV, 2'h0, 1'b1, 1'b1, 18'h3_FFFF, 64'h0);
    rc("q", OFF_ACC_B, 32'hFFFF_FFFA);
    rc("r", OFF_ACC_A, 32'h0000_0000);
    wr(OFF_ACC_A, 32'h0000_0001);
    wr(OFF_ACC_B, 32'h0000_0000);
    op(OP_DIV, 2'h0, 1'b0, 1'b0, 18'h0_0000, 64'h1);
    fl(1'b1, CC_NEG);
    wr(OFF_STATUS, 32'h0000_0001);
    wr(OFF_IDX1, 32'hFFFF_FFFF);
    op(OP_MODX, 2'h1, 1'b1, 1'b0, 18'h0_0000, 64'h1);
    rc("x1", OFF_IDX1, 32'h0000_0000);
    fl(1'b1, CC_ZERO);
    wr(OFF_STATUS, 32'h0000_0001);
    wr(OFF_IDX2, 32'h0000_0005);
    op(OP_MODX, 2'h2, 1'b1, 1'b1, 18'h3_FFFF, 64'h0);
    rc("x2", OFF_IDX2, 32'h0000_0004);
    fl(1'b0, CC_POS);
    wr(OFF_IDX3, 32'h7FFF_FFFF);
    op(OP_MODX, 2'h3, 1'b1, 1'b0, 18'h0_0000, 64'h1);
    rc("x3", OFF_IDX3, 32'h8000_0000);
    fl(1'b0, CC_NEG);
    wr(OFF_ACC_A, 32'h4210_0000);
    op(OP_FADD, SEL_A, 1'b1, 1'b0, 18'h0_0000, 64'h4110_0000);
    rc("fa", OFF_ACC_A, 32'h4211_0000);
    wr(OFF_ACC_A, 32'h4180_0000);
    op(OP_FADD, SEL_A, 1'b1, 1'b0, 18'h0_0000, 64'h4180_0000);
    rc("fa", OFF_ACC_A, 32'h4210_0000);
    wr(OFF_ACC_A, 32'h4210_0000);
    fork
      op(OP_FADD, SEL_A, 1'b1, 1'b0, 18'h0_0000, 64'hC1FF_FFFF);
      begin
        // busy shown and operand writes refused while the add runs
        repeat (2) @(posedge pclk);
        rc("status", OFF_STATUS, 32'h0000_010C);
        apb(1'b1, OFF_ACC_A, 32'h0000_0000);
        chk("err", 64'h1, 64'(re));
      end
    join
    rc("fa", OFF_ACC_A, 32'h3C10_0000);
    wr(OFF_ACC_A, 32'h4110_0000);
    op(OP_FADD, SEL_A, 1'b1, 1'b0, 18'h0_0000, 64'hC110_0000);
    rc("fa", OFF_ACC_A, 32'h0000_0000);
    fl(1'b0, CC_ZERO);
    wr(OFF_ACC_A, 32'h4110_0000);
    wr(OFF_ACC_B, 32'h0000_0000);
    op(OP_FADD, SEL_D, 1'b1, 1'b0, 18'h0_0000, 64'h4110_0000_0000_0001);
    rc("fd", OFF_ACC_A, 32'h4120_0000);
    rc("fd", OFF_ACC_B, 32'h0000_0001);
    wr(OFF_ACC_A, 32'h0010_0000);
    op(OP_FADD, SEL_A, 1'b1, 1'b0, 18'h0_0000, 64'h8008_0000);
    rc("fa", OFF_ACC_A, 32'h0000_0000);
    fl(1'b1, CC_ZERO);
    wr(OFF_STATUS, 32'h0000_0001);
    wr(OFF_ACC_A, 32'h7F80_0000);
    op(OP_FADD, SEL_A, 1'b1, 1'b0, 18'h0_0000, 64'h7F80_0000);
    chk("ov", 64'h1, 64'(ov_flag));
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk("err", 64'h1, 64'(re));
    test_done;
  end
endmodule // tb
